// file: gauge_alert_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the alert, status and shutdown-timing block.
`ifndef GAUGE_ALERT_REGS_VH
`define GAUGE_ALERT_REGS_VH

// Register word addresses
`define ADDR_STATUS 8'h00
`define ADDR_VALERT 8'h01
`define ADDR_TALERT 8'h02
`define ADDR_SALERT 8'h03
`define ADDR_CELL_V 8'h09
`define ADDR_CONFIG 8'h1d
`define ADDR_VERSION 8'h21
`define ADDR_TIMER 8'h3e
`define ADDR_SD_DELAY 8'h3f

// Status register bit positions
`define ST_POR 1
`define ST_BST 3
`define ST_VMN 8
`define ST_TMN 9
`define ST_SMN 10
`define ST_INSERT 11
`define ST_VMX 12
`define ST_TMX 13
`define ST_SMX 14
`define ST_REMOVE 15

// Config register bit positions
`define CF_BER 0
`define CF_BEI 1
`define CF_AEN 2
`define CF_ALSH 5
`define CF_BUS_IDLE_SD 6
`define CF_FORCE_SD 7
`define CF_REMOVAL_SD 10
`define CF_ALERT_POL 11
`define CF_VOLT_STICKY 12
`define CF_TEMP_STICKY 13
`define CF_SS 14

// Reset values
`define RST_STATUS 16'h0002
`define RST_CONFIG 16'h2340
`define RST_VALERT 16'hff00
`define RST_TALERT 16'h7f80
`define RST_SALERT 16'hff00
`define RST_THR 3'h7

// Timing: task period in picoseconds and clock period in picoseconds
`define TASK_PERIOD_PS 175800000
`define CLK_PERIOD_PS 4000
`define TASK_CYCLES (`TASK_PERIOD_PS / `CLK_PERIOD_PS)
// Shutdown counter advances every eight task periods (1.4ms)
`define CTR_TASKS 8
`define TIMEOUT_BASE_EXP 8

`endif

// file: task_tick.v
// Task-period tick generator: one-cycle pulse every PERIOD clocks.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/1ps
module task_tick #(
    parameter PERIOD = 43950
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Tick out
    output reg tick
);
    reg [31:0] cnt_q;

    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (cnt_q == PERIOD - 1) begin
            cnt_q <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule

// file: gauge_alert_status_shutdown.v
// Alert flags, alert configuration, shutdown delay and timer registers.
// Assumes a simple word register port driven on CLK, measurement samples
// presented by the front end, and pin levels from outside the clock domain.
//
// Summary of operation
// - Removal held past timeout enters shutdown
// - Removal-enable wakes when aux input falls
// - Both enables clear: wake on any SDA, SCL or alert pin edge
// - Polarity bit: 0 active low, 1 high
// - Voltage sticky holds flags, else self-clear
// - Temperature sticky likewise, resets to one
// - Charge sticky likewise, resets to zero
// - Elapsed count steps 1.4ms, clears at end
// - Timeout is task period times 2^(8+sel)
// - Timeout done: regulator off, low power
// - Timer counts task periods, readable
// - Reset flag set on any reset
// - Battery status 1 after removal
// - Voltage under/over flags from samples
// - Voltage over flag follows voltage sticky
// - Temperature under/over flags from samples
// - Charge under/over flags from selected value
// - Insertion flag sticky until cleared
// - Removal flag sticky until cleared
// - Revision register returns fixed value
// - Cell voltage updates each task period outside shutdown
// - Threshold high byte upper, low lower
// - Forced shutdown bit starts delay
`timescale 1ns/1ps
`include "gauge_alert_regs.vh"
module gauge_alert_status_shutdown #(
    // Arbitrary neutral revision value
    parameter [15:0] REVISION = 16'h00a5,
    parameter TASK_CYCLES = `TASK_CYCLES
) (
    // Clock and reset
    input wire CLK,
    input wire SYS_RST,
    // Register port
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    output reg [15:0] REG_RDATA,
    output reg REG_RVALID,
    // Measurement samples from the front end
    input wire [15:0] CELL_VOLTAGE_SAMPLE,
    input wire [7:0] TEMP_SAMPLE,
    input wire [7:0] CHARGE_SAMPLE,
    // Pins, asynchronous to CLK
    input wire AUX_REMOVED,
    input wire SDA_IN,
    input wire SCL_IN,
    input wire ALERT_PIN_IN,
    // Alert pin, open drain
    output reg ALERT_PIN_OUT,
    output reg ALERT_PIN_OE,
    // Power state
    output reg SHUTDOWN,
    output reg REGULATOR_EN
);
    // Pin synchronisers: stage one read only by stage two
    reg [3:0] meta_q;
    reg [3:0] sync_q;
    reg [3:0] prev_q;
    always @(posedge CLK) begin
        if (SYS_RST) begin
            // Idle levels of the pulled-up lines, so no false edge follows reset
            meta_q <= 4'he;
            sync_q <= 4'he;
            prev_q <= 4'he;
        end else begin
            meta_q <= {ALERT_PIN_IN, SCL_IN, SDA_IN, AUX_REMOVED};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
    wire aux_s = sync_q[0];
    wire bus_low = ~sync_q[1] & ~sync_q[2];
    wire [3:0] edges = sync_q ^ prev_q;

    wire tick;
    task_tick #(
        .PERIOD(TASK_CYCLES)
    ) u_tick (
        .clk(CLK),
        .rst(SYS_RST),
        .tick(tick)
    );

    reg [15:0] status_q;
    reg [15:0] config_q;
    reg [15:0] valert_q;
    reg [15:0] talert_q;
    reg [15:0] salert_q;
    reg [15:0] cell_v_q;
    reg [15:0] timer_q;
    reg [2:0] thr_q;
    reg [12:0] elapsed_q;
    reg [2:0] sub_q;
    reg [23:0] task_cnt_q;
    reg sample_pend_q;
    reg aux_prev_q;

    wire wr_status = REG_WR && (REG_ADDR == `ADDR_STATUS);
    wire wr_config = REG_WR && (REG_ADDR == `ADDR_CONFIG);
    wire wr_sd_delay = REG_WR && (REG_ADDR == `ADDR_SD_DELAY);

    // Shutdown trigger conditions
    wire removal_sd_en = config_q[`CF_REMOVAL_SD];
    wire bus_idle_sd_en = config_q[`CF_BUS_IDLE_SD];
    wire alsh = config_q[`CF_ALSH];
    wire alert_active_in = sync_q[3] ^ ~config_q[`CF_ALERT_POL];
    wire trig = (removal_sd_en & aux_s)
        | config_q[`CF_FORCE_SD]
        | (bus_idle_sd_en & bus_low)
        | (alsh & alert_active_in);
    // Timeout length in task periods: 2^(8+sel)
    wire [23:0] timeout_tasks = 24'h000001 << (`TIMEOUT_BASE_EXP + thr_q);

    // Wake conditions while in shutdown
    wire wake = (removal_sd_en & ~aux_s)
        | (~removal_sd_en & ~bus_idle_sd_en & (|edges[3:1]))
        | (bus_idle_sd_en & ((edges[1] & sync_q[1]) | (edges[2] & sync_q[2])))
        | (alsh & edges[3] & ~alert_active_in);

    // Shutdown delay and power state
    always @(posedge CLK) begin
        if (SYS_RST) begin
            SHUTDOWN <= 1'b0;
            REGULATOR_EN <= 1'b1;
            elapsed_q <= 13'h0000;
            sub_q <= 3'h0;
            task_cnt_q <= 24'h000000;
            thr_q <= `RST_THR;
        end else begin
            if (wr_sd_delay)
                thr_q <= REG_WDATA[15:13];
            if (SHUTDOWN) begin
                if (wake) begin
                    SHUTDOWN <= 1'b0;
                    REGULATOR_EN <= 1'b1;
                end
            end else if (!trig) begin
                elapsed_q <= 13'h0000;
                sub_q <= 3'h0;
                task_cnt_q <= 24'h000000;
            end else if (tick) begin
                if (task_cnt_q + 24'h000001 >= timeout_tasks) begin
                    SHUTDOWN <= 1'b1;
                    REGULATOR_EN <= 1'b0;
                    elapsed_q <= 13'h0000;
                    sub_q <= 3'h0;
                    task_cnt_q <= 24'h000000;
                end else begin
                    task_cnt_q <= task_cnt_q + 24'h000001;
                    sub_q <= sub_q + 3'h1;
                    if (sub_q == `CTR_TASKS - 1)
                        elapsed_q <= elapsed_q + 13'h0001;
                end
            end
        end
    end

    // Timer and cell voltage sampling
    always @(posedge CLK) begin
        if (SYS_RST) begin
            timer_q <= 16'h0000;
            cell_v_q <= 16'h0000;
            sample_pend_q <= 1'b0;
        end else begin
            if (tick && !SHUTDOWN)
                timer_q <= timer_q + 16'h0001;
            // Sample held during shutdown
            if (tick && !SHUTDOWN)
                cell_v_q <= CELL_VOLTAGE_SAMPLE;
            sample_pend_q <= tick & ~SHUTDOWN;
        end
    end

    // Compare stage, one cycle after each new sample
    wire [7:0] vc8 = cell_v_q[15:8];
    wire v_lo = vc8 < valert_q[7:0];
    wire v_hi = vc8 > valert_q[15:8];
    wire t_lo = $signed(TEMP_SAMPLE) < $signed(talert_q[7:0]);
    wire t_hi = $signed(TEMP_SAMPLE) > $signed(talert_q[15:8]);
    wire s_lo = CHARGE_SAMPLE < salert_q[7:0];
    wire s_hi = CHARGE_SAMPLE > salert_q[15:8];

    // Threshold flag update: set wins over software clear
    function flag_next;
        input cur;
        input cond;
        input sticky;
        input clr;
        input eval;
        begin
            if (eval && cond)
                flag_next = 1'b1;
            else if (eval && !sticky)
                flag_next = 1'b0;
            else
                flag_next = cur & ~clr;
        end
    endfunction

    reg [15:0] status_d;
    wire [15:0] clr = wr_status ? ~REG_WDATA : 16'h0000;
    wire aux_rise = aux_s & ~aux_prev_q;
    wire aux_fall = ~aux_s & aux_prev_q;
    always @* begin
        status_d = status_q;
        status_d[`ST_POR] = status_q[`ST_POR] & ~clr[`ST_POR];
        status_d[`ST_BST] = aux_s;
        status_d[`ST_VMN] = flag_next(status_q[`ST_VMN], v_lo, config_q[`CF_VOLT_STICKY],
            clr[`ST_VMN], sample_pend_q);
        status_d[`ST_VMX] = flag_next(status_q[`ST_VMX], v_hi, config_q[`CF_VOLT_STICKY],
            clr[`ST_VMX], sample_pend_q);
        status_d[`ST_TMN] = flag_next(status_q[`ST_TMN], t_lo, config_q[`CF_TEMP_STICKY],
            clr[`ST_TMN], sample_pend_q);
        status_d[`ST_TMX] = flag_next(status_q[`ST_TMX], t_hi, config_q[`CF_TEMP_STICKY],
            clr[`ST_TMX], sample_pend_q);
        status_d[`ST_SMN] = flag_next(status_q[`ST_SMN], s_lo, config_q[`CF_SS],
            clr[`ST_SMN], sample_pend_q);
        status_d[`ST_SMX] = flag_next(status_q[`ST_SMX], s_hi, config_q[`CF_SS],
            clr[`ST_SMX], sample_pend_q);
        status_d[`ST_INSERT] = aux_fall | (status_q[`ST_INSERT] & ~clr[`ST_INSERT]);
        status_d[`ST_REMOVE] = aux_rise | (status_q[`ST_REMOVE] & ~clr[`ST_REMOVE]);
    end
    // Voltage flags use the voltage sticky bit above, compares run
    // only on the cycle after a sample lands

    always @(posedge CLK) begin
        if (SYS_RST) begin
            status_q <= `RST_STATUS;
            config_q <= `RST_CONFIG;
            valert_q <= `RST_VALERT;
            talert_q <= `RST_TALERT;
            salert_q <= `RST_SALERT;
            aux_prev_q <= 1'b0;
        end else begin
            status_q <= status_d;
            aux_prev_q <= aux_s;
            if (wr_config)
                config_q <= {1'b0, REG_WDATA[14:0]};
            else if (SHUTDOWN && wake)
                config_q[`CF_FORCE_SD] <= 1'b0;
            if (REG_WR && REG_ADDR == `ADDR_VALERT)
                valert_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == `ADDR_TALERT)
                talert_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == `ADDR_SALERT)
                salert_q <= REG_WDATA;
        end
    end

    // Alert output: with ALSH clear, any enabled alert drives the pin to its active level
    wire thr_any = |{status_q[`ST_VMN], status_q[`ST_VMX], status_q[`ST_TMN],
        status_q[`ST_TMX], status_q[`ST_SMN], status_q[`ST_SMX]};
    wire alert_req = ~alsh & ((config_q[`CF_AEN] & thr_any)
        | (config_q[`CF_BER] & status_q[`ST_REMOVE])
        | (config_q[`CF_BEI] & status_q[`ST_INSERT]));
    always @(posedge CLK) begin
        if (SYS_RST) begin
            ALERT_PIN_OUT <= 1'b0;
            ALERT_PIN_OE <= 1'b0;
        end else begin
            // Open drain: only the low level is driven
            ALERT_PIN_OUT <= 1'b0;
            ALERT_PIN_OE <= ~alsh & (alert_req ^ config_q[`CF_ALERT_POL]);
        end
    end

    // Read port, one cycle latency; unmapped addresses read zero
    always @(posedge CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 16'h0000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            case (REG_ADDR)
                `ADDR_STATUS: REG_RDATA <= status_q;
                `ADDR_VALERT: REG_RDATA <= valert_q;
                `ADDR_TALERT: REG_RDATA <= talert_q;
                `ADDR_SALERT: REG_RDATA <= salert_q;
                `ADDR_CELL_V: REG_RDATA <= cell_v_q;
                `ADDR_CONFIG: REG_RDATA <= config_q;
                `ADDR_VERSION: REG_RDATA <= REVISION;
                `ADDR_TIMER: REG_RDATA <= timer_q;
                `ADDR_SD_DELAY: REG_RDATA <= {thr_q, elapsed_q};
                default: REG_RDATA <= 16'h0000;
            endcase
        end
    end
endmodule

// file: gauge_alert_chk.sv
// Checker for the alert, status and shutdown block.
// Sees only top ports; it shadows config writes to know the enables.
`timescale 1ns/1ps
module gauge_alert_chk #(
    parameter [15:0] REVISION = 16'h00a5
) (
    // Clock and reset
    input wire CLK,
    input wire SYS_RST,
    // Register port
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire [15:0] REG_RDATA,
    input wire REG_RVALID,
    // Pins and power
    input wire AUX_REMOVED,
    input wire SDA_IN,
    input wire SCL_IN,
    input wire ALERT_PIN_OUT,
    input wire ALERT_PIN_OE,
    input wire SHUTDOWN,
    input wire REGULATOR_EN
);
    // Shadow misses the wake-time clear of the forced bit, so bit 7 is used loosely
    reg [15:0] cfg_q;
    reg por_q;
    always @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_q <= 16'h2340;
            por_q <= 1'b1;
        end else if (REG_WR) begin
            if (REG_ADDR == 8'h1d) cfg_q <= REG_WDATA;
            if (REG_ADDR == 8'h00) por_q <= por_q & REG_WDATA[1];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    AST_OUT_LOW: assert property (ALERT_PIN_OUT == 1'b0)
        else $error("alert output not low");
    AST_OE_POL: assert property ((!SHUTDOWN && (cfg_q & 16'h0027) == 16'h0000
        && $stable(cfg_q)) [*3] |-> ALERT_PIN_OE == cfg_q[11])
        else $error("alert enable disagrees with polarity");
    AST_RVALID: assert property (REG_RVALID == $past(REG_RD))
        else $error("read valid not one cycle after read");
    AST_VERSION: assert property (REG_RD && REG_ADDR == 8'h21 |=> REG_RDATA == REVISION)
        else $error("revision read wrong");
    AST_POR: assert property (REG_RD && REG_ADDR == 8'h00 && por_q |=> REG_RDATA[1])
        else $error("reset flag lost");
    AST_REGULATOR: assert property (SHUTDOWN != REGULATOR_EN)
        else $error("regulator on in shutdown");
    AST_ENTER: assert property ($rose(SHUTDOWN) |-> (cfg_q & 16'h04e0) != 16'h0000)
        else $error("shutdown without a trigger enabled");
    AST_WAKE_AUX: assert property (SHUTDOWN && cfg_q[10] && $fell(AUX_REMOVED)
        |-> ##[1:8] !SHUTDOWN)
        else $error("no wake on insertion");
    AST_WAKE_EDGE: assert property (SHUTDOWN && !cfg_q[10] && !cfg_q[6]
        && ($changed(SCL_IN) || $changed(SDA_IN)) |-> ##[1:8] !SHUTDOWN)
        else $error("no wake on bus edge");
    cover property ($rose(SHUTDOWN));
    cover property ($fell(SHUTDOWN));
    cover property (REG_RD && REG_ADDR == 8'h21);
endmodule

bind gauge_alert_status_shutdown gauge_alert_chk #(.REVISION(REVISION)) u_chk (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID),
    .AUX_REMOVED(AUX_REMOVED),
    .SDA_IN(SDA_IN),
    .SCL_IN(SCL_IN),
    .ALERT_PIN_OUT(ALERT_PIN_OUT),
    .ALERT_PIN_OE(ALERT_PIN_OE),
    .SHUTDOWN(SHUTDOWN),
    .REGULATOR_EN(REGULATOR_EN)
);

// file: gauge_host_model.sv
// Host side of the word register port.
// Assumes the bench clock; changes the port just after falling edges.
`timescale 1ns/1ps
module gauge_host_model (
    // Clock
    input wire CLK,
    // Register port
    output reg REG_WR,
    output reg REG_RD,
    output reg [7:0] REG_ADDR,
    output reg [15:0] REG_WDATA,
    input wire [15:0] REG_RDATA,
    input wire REG_RVALID
);
    initial begin
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 16'h0000;
    end
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(negedge CLK);
            REG_ADDR = a;
            REG_WDATA = d;
            REG_WR = 1'b1;
            @(negedge CLK);
            REG_WR = 1'b0;
            // Stale data is inverted so nothing relies on it
            REG_WDATA = ~d;
        end
    endtask
    task rd(input [7:0] a, output [15:0] d, output v);
        begin
            @(negedge CLK);
            REG_ADDR = a;
            REG_RD = 1'b1;
            @(negedge CLK);
            d = REG_RDATA;
            v = REG_RVALID;
            REG_RD = 1'b0;
        end
    endtask
endmodule

// file: gauge_alert_status_shutdown_test.sv
// Testbench for the alert, status and shutdown block.
// Uses the host model for register access and drives samples and pins.
`timescale 1ns/1ps
module gauge_alert_status_shutdown_test;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [15:0] vsamp = 16'h6000;
    reg [7:0] tsamp = 8'h08;
    reg [7:0] csamp = 8'h20;
    reg aux = 1'b0;
    reg sda = 1'b1;
    reg scl = 1'b1;
    wire wr, rd, rvalid, aout, aoe, sd_out, regen;
    wire [7:0] addr;
    wire [15:0] wdata, rdata;
    // Open-drain alert line with its pull-up
    wire alin = ~aoe;
    integer errors = 0;
    integer cmp_count = 0;
    integer n;
    reg [15:0] t1, t2;
    reg v;
    gauge_alert_status_shutdown #(.TASK_CYCLES(4)) u_gauge_alert_status_shutdown (
        .CLK(clk), .SYS_RST(sys_rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .CELL_VOLTAGE_SAMPLE(vsamp), .TEMP_SAMPLE(tsamp), .CHARGE_SAMPLE(csamp),
        .AUX_REMOVED(aux), .SDA_IN(sda), .SCL_IN(scl), .ALERT_PIN_IN(alin),
        .ALERT_PIN_OUT(aout), .ALERT_PIN_OE(aoe), .SHUTDOWN(sd_out), .REGULATOR_EN(regen));
    gauge_host_model host (.CLK(clk), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid));
    initial begin
        forever #2 clk = ~clk;
    end
    task report_and_stop;
        begin
            if (errors == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task rchk(input string nm, input [7:0] a, input [15:0] e);
        reg [15:0] d;
        reg ok;
        begin
            host.rd(a, d, ok);
            chk(nm, (ok === 1'b1) ? d : 16'hdead, e);
        end
    endtask
    // Samples are taken at ticks; twelve cycles span at least two of them
    task step(input [15:0] v_in, input [7:0] t_in, input [7:0] c_in, input [15:0] e);
        begin
            vsamp = v_in;
            tsamp = t_in;
            csamp = c_in;
            repeat (12) @(negedge clk);
            rchk("status", 8'h00, e);
        end
    endtask
    task wait_sd(input lvl, input integer lim, output integer cnt);
        begin
            cnt = 0;
            while (sd_out !== lvl && cnt < lim) begin
                @(negedge clk);
                cnt = cnt + 1;
            end
            if (cnt >= lim) begin
                errors = errors + 1;
                report_and_stop;
            end
        end
    endtask
    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        rchk("status", 8'h00, 16'h0002);
        rchk("config", 8'h1d, 16'h2340);
        rchk("valert", 8'h01, 16'hff00);
        rchk("sd_delay", 8'h3f, 16'he000);
        host.wr(8'h21, 16'h1234);
        rchk("version", 8'h21, 16'h00a5);
        rchk("unmapped", 8'h55, 16'h0000);
        host.wr(8'h00, 16'h0000);
        rchk("status", 8'h00, 16'h0000);
        host.wr(8'h01, 16'h8040);
        host.wr(8'h02, 16'h1000);
        host.wr(8'h03, 16'h5010);
        step(16'h9000, 8'h08, 8'h20, 16'h1000);
        step(16'h6000, 8'h08, 8'h20, 16'h0000);
        step(16'h6000, 8'h20, 8'h20, 16'h2000);
        step(16'h6000, 8'h08, 8'h20, 16'h2000);
        step(16'h6000, 8'h08, 8'h05, 16'h2400);
        step(16'h6000, 8'h08, 8'h60, 16'h6000);
        host.wr(8'h00, 16'h0000);
        host.wr(8'h1d, 16'h3340);
        step(16'h3000, 8'h08, 8'h20, 16'h0100);
        step(16'h6000, 8'h08, 8'h20, 16'h0100);
        host.wr(8'h00, 16'h0000);
        rchk("status", 8'h00, 16'h0000);
        rchk("cell_v", 8'h09, 16'h6000);
        host.rd(8'h3e, t1, v);
        repeat (38) @(negedge clk);
        host.rd(8'h3e, t2, v);
        chk("timer", t2 - t1, 16'h000a);
        host.wr(8'h3f, 16'h0000);
        host.wr(8'h1d, 16'h2700);
        aux = 1'b1;
        repeat (8) @(negedge clk);
        rchk("status", 8'h00, 16'h8008);
        wait_sd(1'b1, 1100, n);
        chk("delay", n > 990 && n < 1030, 16'h0001);
        chk("regen", regen, 16'h0000);
        rchk("sd_delay", 8'h3f, 16'h0000);
        aux = 1'b0;
        wait_sd(1'b0, 10, n);
        rchk("status", 8'h00, 16'h8800);
        host.wr(8'h00, 16'h0000);
        host.wr(8'h3f, 16'h2000);
        host.wr(8'h1d, 16'h2380);
        wait_sd(1'b1, 2100, n);
        chk("delay", n > 2030 && n < 2060, 16'h0001);
        vsamp = 16'h7000;
        repeat (12) @(negedge clk);
        rchk("cell_v", 8'h09, 16'h6000);
        #40 scl = 1'b0;
        #80 scl = 1'b1;
        wait_sd(1'b0, 40, n);
        rchk("config", 8'h1d, 16'h2300);
        chk("oe", aoe, 16'h0000);
        host.wr(8'h1d, 16'h2b00);
        repeat (4) @(negedge clk);
        chk("oe", aoe, 16'h0001);
        host.wr(8'h1d, 16'h2300);
        repeat (4) @(negedge clk);
        chk("oe", aoe, 16'h0000);
        report_and_stop;
    end
endmodule
